// *** core/mocg_top.sv ***
`timescale 1ns/1ps
`include "mocg_defs.svh"

module mocg_top
    import mocg_pkg::*;
(
    // clock, reset, enable
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_clock_en,
    // clock pins
    input wire logic i_slow_clock,
    input wire logic i_main_clock,
    // axi4-lite write address
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    // axi4-lite write data
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // axi4-lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // axi4-lite read address
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    // axi4-lite read data
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // oscillator and pll controls
    output logic o_osc_enable,
    output logic o_osc_bypass,
    output logic o_main_select,
    output logic [7:0] o_pll_a_div,
    output logic [10:0] o_pll_a_mul,
    output logic o_pll_a_run,
    output logic [7:0] o_pll_b_div,
    output logic [10:0] o_pll_b_mul,
    output logic o_pll_b_run,
    // interrupt
    output logic o_irq
);

    // pin synchronisers
    logic slow_s1_q, slow_s2_q, slow_s3_q;
    logic main_s1_q, main_s2_q, main_s3_q;
    logic slow_rise, slow_fall, main_rise;

    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            slow_s1_q <= 1'b0;
            slow_s2_q <= 1'b0;
            slow_s3_q <= 1'b0;
            main_s1_q <= 1'b0;
            main_s2_q <= 1'b0;
            main_s3_q <= 1'b0;
        end
        else if (i_clock_en)
        begin
            slow_s1_q <= i_slow_clock;
            slow_s2_q <= slow_s1_q;
            slow_s3_q <= slow_s2_q;
            main_s1_q <= i_main_clock;
            main_s2_q <= main_s1_q;
            main_s3_q <= main_s2_q;
        end
    end

    assign slow_rise = slow_s2_q & ~slow_s3_q;
    assign slow_fall = ~slow_s2_q & slow_s3_q;
    assign main_rise = main_s2_q & ~main_s3_q;

    // bus slave state
    logic aw_full_q, aw_full_d;
    logic w_full_q, w_full_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic do_write;
    logic wr_osc, wr_pll_a, wr_pll_b, wr_evt, wr_mask;

    // block state
    logic [31:0] osc_ctrl_q, osc_ctrl_d;
    logic [7:0] start_cnt_q, start_cnt_d;
    logic [2:0] prescale_q, prescale_d;
    logic counting_q, counting_d;
    logic stable_q, stable_d;
    logic sel_q, sel_d;
    mocg_freq_state_t fstate_q, fstate_d;
    logic [15:0] fvalue_q, fvalue_d;
    logic [3:0] fperiod_q, fperiod_d;
    logic ready_q, ready_d;
    logic [`MOCG_EVT_WIDTH-1:0] flags, flags_prev_q;
    logic [`MOCG_EVT_WIDTH-1:0] evt_q, evt_d;
    logic [`MOCG_EVT_WIDTH-1:0] mask_q, mask_d;
    logic [31:0] merged;
    logic [31:0] pll_a_cfg, pll_b_cfg;
    logic lock_a, lock_b;

    assign do_write = aw_full_q & w_full_q & ~bvalid_q;
    assign merged = i_wdata;
    assign wr_osc = do_write && (awaddr_q == `MOCG_OFS_OSC_CTRL);
    assign wr_pll_a = do_write && (awaddr_q == `MOCG_OFS_PLL_A);
    assign wr_pll_b = do_write && (awaddr_q == `MOCG_OFS_PLL_B);
    assign wr_evt = do_write && (awaddr_q == `MOCG_OFS_EVENT);
    assign wr_mask = do_write && (awaddr_q == `MOCG_OFS_MASK);

    mocg_pll_ctl u_pll_a (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_clock_en(i_clock_en),
        .i_wr(wr_pll_a),
        .i_wdata(mocg_merge(pll_a_cfg, wdata_q, wstrb_q)),
        .i_slow_tick(slow_rise),
        .o_cfg(pll_a_cfg),
        .o_settled(lock_a),
        .o_run(o_pll_a_run)
    );

    mocg_pll_ctl u_pll_b (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_clock_en(i_clock_en),
        .i_wr(wr_pll_b),
        .i_wdata(mocg_merge(pll_b_cfg, wdata_q, wstrb_q)),
        .i_slow_tick(slow_rise),
        .o_cfg(pll_b_cfg),
        .o_settled(lock_b),
        .o_run(o_pll_b_run)
    );

    assign flags = {ready_q, lock_b, lock_a, stable_q};

    // bus handshakes and register reads
    always_comb
    begin
        aw_full_d = aw_full_q;
        w_full_d = w_full_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (i_awvalid && o_awready)
        begin
            aw_full_d = 1'b1;
            awaddr_d = i_awaddr;
        end
        if (i_wvalid && o_wready)
        begin
            w_full_d = 1'b1;
            wdata_d = merged;
            wstrb_d = i_wstrb;
        end
        if (do_write)
        begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = (wr_osc || wr_pll_a || wr_pll_b || wr_evt || wr_mask ||
                       awaddr_q == `MOCG_OFS_FREQ || awaddr_q == `MOCG_OFS_STATUS) ?
                      `MOCG_RESP_OKAY : `MOCG_RESP_SLVERR;
        end
        if (bvalid_q && i_bready)
        begin
            bvalid_d = 1'b0;
        end
        if (rvalid_q && i_rready)
        begin
            rvalid_d = 1'b0;
        end
        if (i_arvalid && o_arready)
        begin
            rvalid_d = 1'b1;
            rresp_d = `MOCG_RESP_OKAY;
            rdata_d = 32'h0000_0000;
            unique case (i_araddr)
                `MOCG_OFS_OSC_CTRL: rdata_d = osc_ctrl_q;
                `MOCG_OFS_FREQ: rdata_d = {15'h0, ready_q, fvalue_q};
                `MOCG_OFS_PLL_A: rdata_d = pll_a_cfg;
                `MOCG_OFS_PLL_B: rdata_d = pll_b_cfg;
                `MOCG_OFS_STATUS: rdata_d = {28'h0000000, flags};
                `MOCG_OFS_EVENT: rdata_d = {28'h0000000, evt_q};
                `MOCG_OFS_MASK: rdata_d = {28'h0000000, mask_q};
                default: rresp_d = `MOCG_RESP_SLVERR;
            endcase
        end
    end

    // oscillator startup, frequency measure and events
    always_comb
    begin
        osc_ctrl_d = osc_ctrl_q;
        start_cnt_d = start_cnt_q;
        prescale_d = prescale_q;
        counting_d = counting_q;
        stable_d = stable_q;
        fstate_d = fstate_q;
        fvalue_d = fvalue_q;
        fperiod_d = fperiod_q;
        ready_d = ready_q;
        mask_d = mask_q;
        if (counting_q && slow_rise)
        begin
            prescale_d = prescale_q + 3'h1;
            if (prescale_q == `MOCG_STARTUP_PRESCALE)
            begin
                if (start_cnt_q == 8'h00)
                begin
                    stable_d = 1'b1;
                    counting_d = 1'b0;
                end
                else
                begin
                    start_cnt_d = start_cnt_q - 8'h01;
                end
            end
        end
        if (wr_osc)
        begin
            osc_ctrl_d = mocg_merge(osc_ctrl_q, wdata_q, wstrb_q);
            stable_d = 1'b0;
            if (osc_ctrl_d[`MOCG_OSC_EN_BIT])
            begin
                start_cnt_d = osc_ctrl_d[`MOCG_OSC_CNT_MSB:`MOCG_OSC_CNT_LSB];
                prescale_d = 3'h0;
                counting_d = 1'b1;
            end
            else
            begin
                counting_d = 1'b0;
            end
        end
        sel_d = osc_ctrl_d[`MOCG_OSC_SEL_BIT] &&
                (stable_d || (osc_ctrl_d[`MOCG_OSC_BYP_BIT] &&
                              !osc_ctrl_d[`MOCG_OSC_EN_BIT]));
        unique case (fstate_q)
            MOCG_FREQ_IDLE:
            begin
                if (stable_q)
                begin
                    fstate_d = MOCG_FREQ_ARM;
                end
            end
            MOCG_FREQ_ARM:
            begin
                if (slow_rise)
                begin
                    fstate_d = MOCG_FREQ_COUNT;
                    fvalue_d = 16'h0000;
                    fperiod_d = 4'h0;
                end
            end
            MOCG_FREQ_COUNT:
            begin
                if (main_rise)
                begin
                    fvalue_d = fvalue_q + 16'h0001;
                end
                if (slow_fall)
                begin
                    fperiod_d = fperiod_q + 4'h1;
                    if (fperiod_q == `MOCG_FREQ_LAST_PERIOD)
                    begin
                        fstate_d = MOCG_FREQ_DONE;
                        ready_d = 1'b1;
                    end
                end
            end
            MOCG_FREQ_DONE:
            begin
            end
        endcase
        if (!stable_q)
        begin
            fstate_d = MOCG_FREQ_IDLE;
            ready_d = 1'b0;
        end
        if (wr_mask)
        begin
            mask_d = wstrb_q[0] ? wdata_q[`MOCG_EVT_WIDTH-1:0] : mask_q;
        end
        // write one clears, a new rising flag wins
        evt_d = evt_q;
        if (wr_evt && wstrb_q[0])
        begin
            evt_d = evt_q & ~wdata_q[`MOCG_EVT_WIDTH-1:0];
        end
        evt_d = evt_d | (flags & ~flags_prev_q);
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `MOCG_RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `MOCG_RESP_OKAY;
            osc_ctrl_q <= `MOCG_RST_OSC_CTRL;
            start_cnt_q <= 8'h00;
            prescale_q <= 3'h0;
            counting_q <= 1'b0;
            stable_q <= 1'b0;
            sel_q <= 1'b0;
            fstate_q <= MOCG_FREQ_IDLE;
            fvalue_q <= 16'h0000;
            fperiod_q <= 4'h0;
            ready_q <= 1'b0;
            flags_prev_q <= 4'h0;
            evt_q <= 4'h0;
            mask_q <= `MOCG_RST_MASK;
        end
        else if (i_clock_en)
        begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            osc_ctrl_q <= osc_ctrl_d;
            start_cnt_q <= start_cnt_d;
            prescale_q <= prescale_d;
            counting_q <= counting_d;
            stable_q <= stable_d;
            sel_q <= sel_d;
            fstate_q <= fstate_d;
            fvalue_q <= fvalue_d;
            fperiod_q <= fperiod_d;
            ready_q <= ready_d;
            flags_prev_q <= flags;
            evt_q <= evt_d;
            mask_q <= mask_d;
        end
    end

    // outputs
    assign o_awready = ~aw_full_q & ~bvalid_q & i_clock_en;
    assign o_wready = ~w_full_q & ~bvalid_q & i_clock_en;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_arready = ~rvalid_q & i_clock_en;
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;
    assign o_osc_enable = osc_ctrl_q[`MOCG_OSC_EN_BIT];
    assign o_osc_bypass = osc_ctrl_q[`MOCG_OSC_BYP_BIT];
    assign o_main_select = sel_q;
    assign o_pll_a_div = pll_a_cfg[`MOCG_PLL_DIV_MSB:`MOCG_PLL_DIV_LSB];
    assign o_pll_a_mul = pll_a_cfg[`MOCG_PLL_MUL_MSB:`MOCG_PLL_MUL_LSB];
    assign o_pll_b_div = pll_b_cfg[`MOCG_PLL_DIV_MSB:`MOCG_PLL_DIV_LSB];
    assign o_pll_b_mul = pll_b_cfg[`MOCG_PLL_MUL_MSB:`MOCG_PLL_MUL_LSB];
    assign o_irq = |(evt_q & mask_q);

endmodule

// *** core/mocg_defs.svh ***
`ifndef MOCG_DEFS_SVH
`define MOCG_DEFS_SVH

// register byte offsets
`define MOCG_OFS_OSC_CTRL 8'h00
`define MOCG_OFS_FREQ 8'h04
`define MOCG_OFS_PLL_A 8'h08
`define MOCG_OFS_PLL_B 8'h0C
`define MOCG_OFS_STATUS 8'h10
`define MOCG_OFS_EVENT 8'h14
`define MOCG_OFS_MASK 8'h18

// oscillator control fields
`define MOCG_OSC_EN_BIT 0
`define MOCG_OSC_BYP_BIT 1
`define MOCG_OSC_SEL_BIT 2
`define MOCG_OSC_CNT_LSB 8
`define MOCG_OSC_CNT_MSB 15

// frequency measure fields
`define MOCG_FREQ_VAL_MSB 15
`define MOCG_FREQ_RDY_BIT 16

// pll fields
`define MOCG_PLL_DIV_LSB 0
`define MOCG_PLL_DIV_MSB 7
`define MOCG_PLL_CNT_LSB 8
`define MOCG_PLL_CNT_MSB 13
`define MOCG_PLL_MUL_LSB 16
`define MOCG_PLL_MUL_MSB 26

// status, event and mask bit positions
`define MOCG_ST_STABLE 0
`define MOCG_ST_LOCK_A 1
`define MOCG_ST_LOCK_B 2
`define MOCG_ST_READY 3
`define MOCG_EVT_WIDTH 4

// reset values
`define MOCG_RST_OSC_CTRL 32'h0000_0000
`define MOCG_RST_PLL 32'h0000_0000
`define MOCG_RST_MASK 4'h0

// timing counts
`define MOCG_STARTUP_PRESCALE 3'h7
`define MOCG_FREQ_LAST_PERIOD 4'hF

// bus answers
`define MOCG_RESP_OKAY 2'h0
`define MOCG_RESP_SLVERR 2'h2

`endif

// *** core/mocg_pkg.sv ***
package mocg_pkg;

    typedef enum logic [1:0] {
        MOCG_FREQ_IDLE,
        MOCG_FREQ_ARM,
        MOCG_FREQ_COUNT,
        MOCG_FREQ_DONE
    } mocg_freq_state_t;

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] mocg_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

endpackage

// *** core/mocg_pll_ctl.sv ***
`timescale 1ns/1ps
`include "mocg_defs.svh"

module mocg_pll_ctl
    import mocg_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_clock_en,
    // register write
    input wire logic i_wr,
    input wire logic [31:0] i_wdata,
    // slow clock tick
    input wire logic i_slow_tick,
    // state
    output logic [31:0] o_cfg,
    output logic o_settled,
    output logic o_run
);

    logic [31:0] cfg_q, cfg_d;
    logic [5:0] cnt_q, cnt_d;
    logic busy_q, busy_d;
    logic settled_q, settled_d;
    logic run_q, run_d;
    logic [10:0] new_mul;

    always_comb
    begin
        cfg_d = cfg_q;
        cnt_d = cnt_q;
        busy_d = busy_q;
        settled_d = settled_q;
        new_mul = i_wdata[`MOCG_PLL_MUL_MSB:`MOCG_PLL_MUL_LSB];
        if (busy_q && i_slow_tick)
        begin
            if (cnt_q == 6'h00)
            begin
                settled_d = 1'b1;
                busy_d = 1'b0;
            end
            else
            begin
                cnt_d = cnt_q - 6'h01;
            end
        end
        if (i_wr)
        begin
            cfg_d = i_wdata;
            if (new_mul == 11'h000)
            begin
                settled_d = 1'b0;
                busy_d = 1'b0;
            end
            else if (i_wdata != cfg_q)
            begin
                settled_d = 1'b0;
                busy_d = 1'b1;
                cnt_d = i_wdata[`MOCG_PLL_CNT_MSB:`MOCG_PLL_CNT_LSB];
            end
        end
        run_d = (cfg_d[`MOCG_PLL_MUL_MSB:`MOCG_PLL_MUL_LSB] != 11'h000) &&
                (cfg_d[`MOCG_PLL_DIV_MSB:`MOCG_PLL_DIV_LSB] != 8'h00);
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            cfg_q <= `MOCG_RST_PLL;
            cnt_q <= 6'h00;
            busy_q <= 1'b0;
            settled_q <= 1'b0;
            run_q <= 1'b0;
        end
        else if (i_clock_en)
        begin
            cfg_q <= cfg_d;
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            settled_q <= settled_d;
            run_q <= run_d;
        end
    end

    assign o_cfg = cfg_q;
    assign o_settled = settled_q;
    assign o_run = run_q;

endmodule

// *** testbench/mocg_top_assertions.sv ***
`timescale 1ns/1ps

module mocg_top_assertions (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // bus handshakes
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [7:0] i_araddr,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0] o_rresp,
    // clock controls
    input wire logic o_osc_enable,
    input wire logic o_main_select,
    input wire logic [7:0] o_pll_a_div,
    input wire logic [10:0] o_pll_a_mul,
    input wire logic o_pll_a_run,
    input wire logic [7:0] o_pll_b_div,
    input wire logic [10:0] o_pll_b_mul,
    input wire logic o_pll_b_run
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    sequence ar_take;
        i_arvalid && o_arready;
    endsequence
    sequence ar_bad;
        ar_take ##0 (i_araddr > 8'h18);
    endsequence
    sequence wr_take;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence

    reset_state_a: assert property ($rose(i_nrst) |-> !o_osc_enable && !o_main_select
        && o_pll_a_div == 8'h00 && o_pll_b_div == 8'h00 && !o_pll_a_run && !o_pll_b_run)
        else $error("outputs not cleared by reset");
    div_zero_a_a: assert property ((o_pll_a_div == 8'h00) [*2] |-> !o_pll_a_run)
        else $error("pll a runs with zero divider");
    div_zero_b_a: assert property ((o_pll_b_div == 8'h00) [*2] |-> !o_pll_b_run)
        else $error("pll b runs with zero divider");
    mul_zero_a_a: assert property ((o_pll_a_mul == 11'h000) [*2] |-> !o_pll_a_run)
        else $error("pll a runs with zero factor");
    mul_zero_b_a: assert property ((o_pll_b_mul == 11'h000) [*2] |-> !o_pll_b_run)
        else $error("pll b runs with zero factor");
    bvalid_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid)
        else $error("write response dropped early");
    rvalid_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped early");
    wr_answer_a: assert property (wr_take |-> ##[1:2] o_bvalid)
        else $error("write response late");
    rd_answer_a: assert property (ar_take |-> ##[1:2] o_rvalid)
        else $error("read data late");
    rd_unmapped_a: assert property (ar_bad |-> ##[1:2] o_rvalid && o_rresp == 2'h2
        && o_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    busy_refuse_a: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write taken while response pending");
endmodule

bind mocg_top mocg_top_assertions chk (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .i_araddr(i_araddr), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .o_osc_enable(o_osc_enable), .o_main_select(o_main_select),
    .o_pll_a_div(o_pll_a_div), .o_pll_a_mul(o_pll_a_mul), .o_pll_a_run(o_pll_a_run),
    .o_pll_b_div(o_pll_b_div), .o_pll_b_mul(o_pll_b_mul), .o_pll_b_run(o_pll_b_run));

// *** testbench/tb_main_oscillator_clock_generator.sv ***
`timescale 1ns/1ps

module tb_main_oscillator_clock_generator;
    logic i_clock = 1'b0, i_nrst = 1'b0, i_clock_en = 1'b1, i_slow_clock = 1'b0;
    logic i_main_clock = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic i_arvalid = 1'b0, i_rready = 1'b0;
    logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic [3:0] i_wstrb = 4'hF;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_osc_enable, o_osc_bypass;
    logic o_main_select, o_pll_a_run, o_pll_b_run, o_irq;
    logic [1:0] o_bresp, o_rresp;
    logic [31:0] o_rdata, d;
    logic [7:0] o_pll_a_div, o_pll_b_div;
    logic [10:0] o_pll_a_mul, o_pll_b_mul;
    int cyc = 0, mismatches = 0, compares = 0, p;

    mocg_top dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_clock_en(i_clock_en),
        .i_slow_clock(i_slow_clock), .i_main_clock(i_main_clock), .i_awvalid(i_awvalid),
        .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid), .o_wready(o_wready),
        .i_wdata(i_wdata), .i_wstrb(i_wstrb), .o_bvalid(o_bvalid), .i_bready(i_bready),
        .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
        .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
        .o_osc_enable(o_osc_enable), .o_osc_bypass(o_osc_bypass),
        .o_main_select(o_main_select), .o_pll_a_div(o_pll_a_div), .o_pll_a_mul(o_pll_a_mul),
        .o_pll_a_run(o_pll_a_run), .o_pll_b_div(o_pll_b_div), .o_pll_b_mul(o_pll_b_mul),
        .o_pll_b_run(o_pll_b_run), .o_irq(o_irq));

    initial forever #25 i_clock = ~i_clock;

    // slow clock period 20 cycles, free running; main clock period 4 cycles
    always @(posedge i_clock)
    begin
        cyc <= cyc + 1;
        if (cyc % 10 == 9)
            i_slow_clock <= ~i_slow_clock;
        if (cyc % 2 == 1)
            i_main_clock <= ~i_main_clock;
    end

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_in(input string nm, input int lo, input int hi, input logic [31:0] got);
        compares++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            mismatches++;
            $display("BAD %s expected %0d to %0d seen %0d", nm, lo, hi, got);
        end
    endtask

    task automatic give_up;
        mismatches++;
        tally_and_finish();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        int n;
        i_awaddr <= a;
        i_wdata <= v;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        for (n = 0; n < 200; n++)
        begin
            @(posedge i_clock);
            if (i_awvalid && o_awready === 1'b1)
                i_awvalid <= 1'b0;
            if (i_wvalid && o_wready === 1'b1)
                i_wvalid <= 1'b0;
            if (o_bvalid === 1'b1)
                break;
        end
        if (n == 200)
            give_up();
        chk("bresp", er, o_bresp);
        i_bready <= 1'b0;
        @(posedge i_clock);
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        int n;
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        for (n = 0; n < 200; n++)
        begin
            @(posedge i_clock);
            if (i_arvalid && o_arready === 1'b1)
                i_arvalid <= 1'b0;
            if (o_rvalid === 1'b1)
                break;
        end
        if (n == 200)
            give_up();
        d = o_rdata;
        chk("rresp", er, o_rresp);
        i_rready <= 1'b0;
        @(posedge i_clock);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
        rd(a, 2'h0);
        chk(nm, exp, d & m);
    endtask

    // poll one status bit until set, then judge the time it took
    task automatic wait_st(input string nm, input int b, input int lo, input int hi);
        int n, t0;
        t0 = cyc;
        for (n = 0; n < 400; n++)
        begin
            rd(8'h10, 2'h0);
            if (d[b] === 1'b1)
                break;
        end
        if (n == 400)
            give_up();
        chk_in(nm, lo, hi, cyc - t0);
    endtask

    initial
    begin
        repeat (16) @(posedge i_clock);
        i_nrst <= 1'b1;
        @(posedge i_clock);
        @(posedge i_clock);
        chk("osc_enable", 0, o_osc_enable);
        chk("main_select", 0, o_main_select);
        rdc("osc_ctrl", 8'h00, 32'hFFFF_FFFF, 0);
        rdc("pll_a", 8'h08, 32'hFFFF_FFFF, 0);
        rdc("pll_b", 8'h0C, 32'hFFFF_FFFF, 0);
        rdc("mask", 8'h18, 32'hFFFF_FFFF, 0);
        rd(8'h40, 2'h2);
        chk("unmapped_data", 0, d);
        wr(8'h40, 32'hFFFF_FFFF, 2'h2);
        wr(8'h10, 32'hFFFF_FFFF, 2'h0);
        rdc("status_ro", 8'h10, 32'hF, 0);
        wr(8'h00, 32'h0000_0105, 2'h0);
        rdc("stable_early", 8'h10, 32'h1, 0);
        wait_st("startup_time", 0, 160, 380);
        chk("irq_masked", 0, o_irq);
        chk("main_select_on", 1, o_main_select);
        wait_st("measure_time", 3, 290, 400);
        rd(8'h04, 2'h0);
        chk("freq_ready", 1, d[16]);
        chk_in("freq_value", 76, 81, d[15:0]);
        rdc("event_stable", 8'h14, 32'h1, 32'h1);
        wr(8'h18, 32'h0000_0001, 2'h0);
        repeat (2) @(posedge i_clock);
        chk("irq_unmasked", 1, o_irq);
        wr(8'h14, 32'h0000_0001, 2'h0);
        repeat (2) @(posedge i_clock);
        chk("irq_cleared", 0, o_irq);
        wr(8'h00, 32'h0000_0104, 2'h0);
        rdc("stable_off", 8'h10, 32'h9, 0);
        wr(8'h00, 32'h0000_0305, 2'h0);
        repeat (400) @(posedge i_clock);
        rdc("stable_mid", 8'h10, 32'h1, 0);
        wr(8'h00, 32'h0000_0305, 2'h0);
        wait_st("restart_time", 0, 480, 700);
        wr(8'h00, 32'h0000_0105, 2'h0);
        rdc("stable_rewrite", 8'h10, 32'h1, 0);
        wait_st("rewrite_time", 0, 160, 380);
        wr(8'h00, 32'h0000_0006, 2'h0);
        repeat (2) @(posedge i_clock);
        chk("bypass", 1, o_osc_bypass);
        chk("bypass_enable", 0, o_osc_enable);
        chk("bypass_select", 1, o_main_select);
        rdc("bypass_stable", 8'h10, 32'h1, 0);
        for (p = 0; p < 2; p++)
        begin
            wr(8'h08 + 8'(4 * p), 32'h0009_0304, 2'h0);
            wait_st("settle_time", 1 + p, 40, 140);
            chk("pll_div", 4, p ? o_pll_b_div : o_pll_a_div);
            chk("pll_mul", 9, p ? o_pll_b_mul : o_pll_a_mul);
            chk("pll_run", 1, p ? o_pll_b_run : o_pll_a_run);
            wr(8'h08 + 8'(4 * p), 32'h0009_0302, 2'h0);
            rdc("settle_clear", 8'h10, 32'h2 << p, 0);
            wait_st("resettle_time", 1 + p, 40, 140);
            wr(8'h08 + 8'(4 * p), 32'h0000_0302, 2'h0);
            rdc("settle_off", 8'h10, 32'h2 << p, 0);
            chk("pll_mul_off", 0, p ? o_pll_b_run : o_pll_a_run);
            wr(8'h08 + 8'(4 * p), 32'h0009_0300, 2'h0);
            repeat (2) @(posedge i_clock);
            chk("pll_div_off", 0, p ? o_pll_b_run : o_pll_a_run);
        end
        i_clock_en <= 1'b0;
        repeat (2) @(posedge i_clock);
        chk("enable_low_ready", 0, o_awready | o_wready | o_arready);
        i_clock_en <= 1'b1;
        @(posedge i_clock);
        tally_and_finish();
    end
endmodule
